// ### rtl/translation_cache_lookup_invalidate.sv
// Translation lookup order and invalidation control
`timescale 1ns/100ps
module translation_cache_lookup_invalidate (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Configuration
   input wire xlat_pkg::paging_mode_type mode_i,
   input wire logic tag_enable_i,
   input wire logic global_page_enable_i,
   input wire logic [xlat_pkg::TAG_W-1:0] address_space_tag_i,
   input wire logic has_dir_cache_i,
   input wire logic has_third_cache_i,
   input wire logic has_top_cache_i,
   // Lookup
   input wire xlat_pkg::lookup_req_type lookup_i,
   output xlat_pkg::lookup_rsp_type lookup_o,
   output logic lookup_ready_o,
   // Walk engine fill
   input wire xlat_pkg::fill_req_type fill_i,
   // Invalidation
   input wire xlat_pkg::inv_req_type inv_i,
   output logic inv_done_o
);
   import xlat_pkg::*;

   typedef struct packed {
      lookup_rsp_type rsp;
      logic inv_done;
      logic ready;
   } top_state_type;

   top_state_type s_q;
   top_state_type s_d;

   logic [VPN_W-1:0] look_vpn;
   logic [DIR_IDX_W-1:0] dir_idx;
   logic [DIR_IDX_W-1:0] third_idx;
   logic [DIR_IDX_W-1:0] top_idx;
   logic tlb_hit;
   logic dir_hit;
   logic third_hit;
   logic top_hit;
   tlb_entry_type tlb_ent;
   psc_entry_type dir_ent;
   psc_entry_type third_ent;
   psc_entry_type top_ent;
   logic [DIR_IDX_W-1:0] fill_dir_idx;
   logic [DIR_IDX_W-1:0] fill_idx;
   logic [DIR_IDX_W-1:0] fault_dir_idx;
   logic [DIR_IDX_W-1:0] fault_third_idx;
   logic [DIR_IDX_W-1:0] fault_top_idx;
   tlb_entry_type tlb_fill;
   psc_entry_type psc_fill;
   logic t_all;
   logic t_nonglobal;
   logic t_page;
   logic t_page_tagged;
   logic p_all;
   logic p_tag;
   logic p_fault;
   logic [TAG_W-1:0] fl_tag;
   logic [VPN_W-1:0] fl_vpn;
   logic long_mode;

   function automatic logic [DIR_IDX_W-1:0] dir_index(
      input paging_mode_type m, input logic [LIN_W-1:0] a);
      logic [DIR_IDX_W-1:0] r;
      r = '0;
      case (m)
         MODE_32: r[P32_DIR_W-1:0] = a[P32_DIR_LSB +: P32_DIR_W];
         MODE_EXT: r[EXT_DIR_W-1:0] = a[EXT_DIR_LSB +: EXT_DIR_W];
         default: r = a[LONG_DIR_LSB +: DIR_IDX_W];
      endcase
      return r;
   endfunction : dir_index

   function automatic logic [DIR_IDX_W-1:0] third_index(
      input logic [LIN_W-1:0] a);
      return {{(DIR_IDX_W-THIRD_IDX_W){1'b0}},
              a[LONG_THIRD_LSB +: THIRD_IDX_W]};
   endfunction : third_index

   function automatic logic [DIR_IDX_W-1:0] top_index(
      input logic [LIN_W-1:0] a);
      return {{(DIR_IDX_W-TOP_IDX_W){1'b0}},
              a[LONG_TOP_LSB +: TOP_IDX_W]};
   endfunction : top_index

   assign long_mode = mode_i == MODE_LONG;
   assign look_vpn = lookup_i.lin[LIN_W-1:PAGE_LSB];
   assign dir_idx = dir_index(mode_i, lookup_i.lin);
   assign third_idx = third_index(lookup_i.lin);
   assign top_idx = top_index(lookup_i.lin);
   assign fault_dir_idx = dir_index(mode_i, inv_i.operand[LIN_W-1:0]);
   assign fault_third_idx = third_index(inv_i.operand[LIN_W-1:0]);
   assign fault_top_idx = top_index(inv_i.operand[LIN_W-1:0]);

   // Invalidation decode
   always_comb begin
      t_all = 1'b0;
      t_nonglobal = 1'b0;
      t_page = 1'b0;
      t_page_tagged = 1'b0;
      p_all = 1'b0;
      p_tag = 1'b0;
      p_fault = 1'b0;
      fl_tag = address_space_tag_i;
      fl_vpn = inv_i.operand[LIN_W-1:PAGE_LSB];
      if (inv_i.valid) begin
         case (inv_i.kind)
            INV_PAGE: begin
               t_page = 1'b1;
               p_tag = 1'b1;
            end
            INV_BASE: begin
               if (!tag_enable_i) begin
                  fl_tag = TAG_ZERO;
                  t_nonglobal = 1'b1;
                  p_tag = 1'b1;
               end else if (!inv_i.operand[BASE_NOFLUSH_BIT]) begin
                  fl_tag = inv_i.operand[TAG_W-1:0];
                  t_nonglobal = 1'b1;
                  p_tag = 1'b1;
               end
               // With tags enabled, bit 63 set keeps everything
            end
            INV_FEATURE: begin
               if ((inv_i.pge_old != inv_i.pge_new) ||
                   (inv_i.tag_en_old && !inv_i.tag_en_new)) begin
                  t_all = 1'b1;
                  p_all = 1'b1;
               end
            end
            INV_TASK: begin
               fl_tag = TAG_ZERO;
               t_nonglobal = 1'b1;
               p_tag = 1'b1;
            end
            INV_FAULT: begin
               t_page = 1'b1;
               t_page_tagged = 1'b1;
               p_fault = 1'b1;
            end
            default: begin
               t_all = 1'b0;
            end
         endcase
      end
   end

   // Fill entries from the walk engine
   always_comb begin
      tlb_fill = '0;
      tlb_fill.valid = 1'b1;
      tlb_fill.global_flag = fill_i.pte_low[GLOBAL_BIT] &&
         global_page_enable_i;
      tlb_fill.tag = address_space_tag_i;
      tlb_fill.vpn = fill_i.lin[LIN_W-1:PAGE_LSB];
      tlb_fill.pa = fill_i.pa;
      tlb_fill.attr = fill_i.attr;
      fill_dir_idx = dir_index(mode_i, fill_i.lin);
      case (fill_i.level)
         HIT_THIRD: fill_idx = third_index(fill_i.lin);
         HIT_TOP: fill_idx = top_index(fill_i.lin);
         default: fill_idx = fill_dir_idx;
      endcase
      psc_fill = '0;
      psc_fill.valid = 1'b1;
      psc_fill.tag = address_space_tag_i;
      psc_fill.idx = fill_idx;
      psc_fill.pa = fill_i.pa;
      psc_fill.attr = fill_i.attr;
   end

   tlb_array u_tlb (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .vpn_i(look_vpn),
      .cur_tag_i(address_space_tag_i),
      .hit_o(tlb_hit),
      .hit_entry_o(tlb_ent),
      .fill_i(fill_i.valid && fill_i.level == HIT_TLB && !inv_i.valid),
      .fill_entry_i(tlb_fill),
      .fl_all_i(t_all),
      .fl_nonglobal_i(t_nonglobal),
      .fl_page_i(t_page),
      .fl_page_tagged_i(t_page_tagged),
      .fl_tag_i(fl_tag),
      .fl_vpn_i(fl_vpn)
   );

   psc_array u_dir (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .idx_i(dir_idx),
      .cur_tag_i(address_space_tag_i),
      .hit_o(dir_hit),
      .hit_entry_o(dir_ent),
      .fill_i(fill_i.valid && fill_i.level == HIT_DIR && !inv_i.valid &&
              has_dir_cache_i),
      .fill_entry_i(psc_fill),
      .fl_all_i(p_all),
      .fl_tag_only_i(p_tag),
      .fl_idx_i(p_fault),
      .fl_tag_i(fl_tag),
      .fl_idx_val_i(fault_dir_idx)
   );

   psc_array u_third (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .idx_i(third_idx),
      .cur_tag_i(address_space_tag_i),
      .hit_o(third_hit),
      .hit_entry_o(third_ent),
      .fill_i(fill_i.valid && fill_i.level == HIT_THIRD && !inv_i.valid &&
              has_third_cache_i && long_mode),
      .fill_entry_i(psc_fill),
      .fl_all_i(p_all),
      .fl_tag_only_i(p_tag),
      .fl_idx_i(p_fault),
      .fl_tag_i(fl_tag),
      .fl_idx_val_i(fault_third_idx)
   );

   psc_array u_top (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .idx_i(top_idx),
      .cur_tag_i(address_space_tag_i),
      .hit_o(top_hit),
      .hit_entry_o(top_ent),
      .fill_i(fill_i.valid && fill_i.level == HIT_TOP && !inv_i.valid &&
              has_top_cache_i && long_mode),
      .fill_entry_i(psc_fill),
      .fl_all_i(p_all),
      .fl_tag_only_i(p_tag),
      .fl_idx_i(p_fault),
      .fl_tag_i(fl_tag),
      .fl_idx_val_i(fault_top_idx)
   );

   // Ordered lookup; invalidation blocks lookups that cycle
   always_comb begin
      s_d = s_q;
      s_d.rsp = '0;
      s_d.inv_done = inv_i.valid;
      s_d.ready = !inv_i.valid;
      if (lookup_i.valid && !inv_i.valid && s_q.ready) begin
         s_d.rsp.valid = 1'b1;
         if (tlb_hit) begin
            s_d.rsp.level = HIT_TLB;
            s_d.rsp.pa = tlb_ent.pa;
            s_d.rsp.attr = tlb_ent.attr;
         end else if (has_dir_cache_i && dir_hit) begin
            s_d.rsp.level = HIT_DIR;
            s_d.rsp.pa = dir_ent.pa;
            s_d.rsp.attr = dir_ent.attr;
         end else if (long_mode && has_third_cache_i && third_hit) begin
            s_d.rsp.level = HIT_THIRD;
            s_d.rsp.pa = third_ent.pa;
            s_d.rsp.attr = third_ent.attr;
         end else if (long_mode && has_top_cache_i && top_hit) begin
            s_d.rsp.level = HIT_TOP;
            s_d.rsp.pa = top_ent.pa;
            s_d.rsp.attr = top_ent.attr;
         end else begin
            s_d.rsp.level = HIT_NONE;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lookup_o = s_q.rsp;
   assign lookup_ready_o = s_q.ready;
   assign inv_done_o = s_q.inv_done;
endmodule : translation_cache_lookup_invalidate

// ### shared/xlat_pkg.sv
// Shared types and constants for the translation cache block
package xlat_pkg;
   localparam int TAG_W = 12;
   localparam int LIN_W = 48;
   localparam int VPN_W = 36;
   localparam int PA_W = 40;
   localparam int ATTR_W = 8;
   localparam int TLB_N = 8;
   localparam int DIR_N = 4;
   localparam int THIRD_N = 4;
   localparam int TOP_N = 4;
   localparam int TLB_IDX_W = 3;
   localparam int PSC_IDX_W = 2;
   localparam int PAGE_LSB = 12;
   localparam int DIR_IDX_W = 27;
   localparam int THIRD_IDX_W = 18;
   localparam int TOP_IDX_W = 9;
   localparam int LONG_DIR_LSB = 21;
   localparam int LONG_THIRD_LSB = 30;
   localparam int LONG_TOP_LSB = 39;
   localparam int EXT_DIR_LSB = 21;
   localparam int EXT_DIR_W = 11;
   localparam int P32_DIR_LSB = 22;
   localparam int P32_DIR_W = 10;
   localparam int BASE_NOFLUSH_BIT = 63;
   localparam int GLOBAL_BIT = 8;
   localparam logic [TAG_W-1:0] TAG_ZERO = 12'h000;
   localparam logic [TAG_W-1:0] RESET_TAG = 12'h000;

   typedef enum logic [1:0] {
      MODE_32, MODE_EXT, MODE_LONG
   } paging_mode_type;

   // Lookup result: which stage answered
   typedef enum logic [2:0] {
      HIT_TLB, HIT_DIR, HIT_THIRD, HIT_TOP, HIT_NONE
   } hit_level_type;

   typedef enum logic [2:0] {
      INV_NONE, INV_PAGE, INV_BASE, INV_FEATURE, INV_TASK, INV_FAULT
   } inv_kind_type;

   typedef struct packed {
      logic valid;
      logic global_flag;
      logic [TAG_W-1:0] tag;
      logic [VPN_W-1:0] vpn;
      logic [PA_W-1:0] pa;
      logic [ATTR_W-1:0] attr;
   } tlb_entry_type;

   typedef struct packed {
      logic valid;
      logic [TAG_W-1:0] tag;
      logic [DIR_IDX_W-1:0] idx;
      logic [PA_W-1:0] pa;
      logic [ATTR_W-1:0] attr;
   } psc_entry_type;

   typedef struct packed {
      logic valid;
      logic [LIN_W-1:0] lin;
   } lookup_req_type;

   typedef struct packed {
      logic valid;
      hit_level_type level;
      logic [PA_W-1:0] pa;
      logic [ATTR_W-1:0] attr;
   } lookup_rsp_type;

   typedef struct packed {
      logic valid;
      inv_kind_type kind;
      logic [63:0] operand;
      logic pge_old;
      logic pge_new;
      logic tag_en_old;
      logic tag_en_new;
   } inv_req_type;

   // Fill from the walk engine
   typedef struct packed {
      logic valid;
      hit_level_type level;
      logic [LIN_W-1:0] lin;
      logic [PA_W-1:0] pa;
      logic [ATTR_W-1:0] attr;
      logic [GLOBAL_BIT:0] pte_low;
   } fill_req_type;
endpackage : xlat_pkg

// ### rtl/tlb_array.sv
// TLB storage with tag/global match and flush
`timescale 1ns/100ps
module tlb_array (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Lookup
   input wire logic [xlat_pkg::VPN_W-1:0] vpn_i,
   input wire logic [xlat_pkg::TAG_W-1:0] cur_tag_i,
   output logic hit_o,
   output xlat_pkg::tlb_entry_type hit_entry_o,
   // Fill
   input wire logic fill_i,
   input wire xlat_pkg::tlb_entry_type fill_entry_i,
   // Flush controls
   input wire logic fl_all_i,
   input wire logic fl_nonglobal_i,
   input wire logic fl_page_i,
   input wire logic fl_page_tagged_i,
   input wire logic [xlat_pkg::TAG_W-1:0] fl_tag_i,
   input wire logic [xlat_pkg::VPN_W-1:0] fl_vpn_i
);
   import xlat_pkg::*;

   typedef struct packed {
      tlb_entry_type [TLB_N-1:0] ent;
      logic [TLB_IDX_W-1:0] ptr;
   } tlb_state_type;

   tlb_state_type s_q;
   tlb_state_type s_d;
   logic [TLB_N-1:0] match;

   // Several entries may share tag and source; each is its own range
   generate
      for (genvar i = 0; i < TLB_N; i++) begin : g_match
         assign match[i] = s_q.ent[i].valid && s_q.ent[i].vpn == vpn_i &&
            (s_q.ent[i].tag == cur_tag_i || s_q.ent[i].global_flag);
      end
   endgenerate

   always_comb begin
      hit_o = 1'b0;
      hit_entry_o = '0;
      for (int i = 0; i < TLB_N; i++) begin
         if (match[i] && !hit_o) begin
            hit_o = 1'b1;
            hit_entry_o = s_q.ent[i];
         end
      end
   end

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < TLB_N; i++) begin
         if (fl_all_i) begin
            s_d.ent[i].valid = 1'b0;
         end else if (fl_nonglobal_i && !s_q.ent[i].global_flag &&
                      s_q.ent[i].tag == fl_tag_i) begin
            s_d.ent[i].valid = 1'b0;
         end else if (fl_page_i && s_q.ent[i].vpn == fl_vpn_i &&
                      (s_q.ent[i].tag == fl_tag_i ||
                       (s_q.ent[i].global_flag && !fl_page_tagged_i))) begin
            // Only entries with this exact vpn are removed; other small pieces of a large page have other vpns
            s_d.ent[i].valid = 1'b0;
         end
      end
      if (fill_i) begin
         s_d.ent[s_q.ptr] = fill_entry_i;
         s_d.ptr = s_q.ptr + 1'b1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : tlb_array

// ### rtl/psc_array.sv
// One paging-structure cache level, tag-matched and flushable
`timescale 1ns/100ps
module psc_array (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Lookup
   input wire logic [xlat_pkg::DIR_IDX_W-1:0] idx_i,
   input wire logic [xlat_pkg::TAG_W-1:0] cur_tag_i,
   output logic hit_o,
   output xlat_pkg::psc_entry_type hit_entry_o,
   // Fill
   input wire logic fill_i,
   input wire xlat_pkg::psc_entry_type fill_entry_i,
   // Flush controls
   input wire logic fl_all_i,
   input wire logic fl_tag_only_i,
   input wire logic fl_idx_i,
   input wire logic [xlat_pkg::TAG_W-1:0] fl_tag_i,
   input wire logic [xlat_pkg::DIR_IDX_W-1:0] fl_idx_val_i
);
   import xlat_pkg::*;

   typedef struct packed {
      psc_entry_type [DIR_N-1:0] ent;
      logic [PSC_IDX_W-1:0] ptr;
   } psc_state_type;

   psc_state_type s_q;
   psc_state_type s_d;
   logic [DIR_N-1:0] match;

   generate
      for (genvar i = 0; i < DIR_N; i++) begin : g_match
         assign match[i] = s_q.ent[i].valid && s_q.ent[i].idx == idx_i &&
            s_q.ent[i].tag == cur_tag_i;
      end
   endgenerate

   always_comb begin
      hit_o = 1'b0;
      hit_entry_o = '0;
      for (int i = 0; i < DIR_N; i++) begin
         if (match[i] && !hit_o) begin
            hit_o = 1'b1;
            hit_entry_o = s_q.ent[i];
         end
      end
   end

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < DIR_N; i++) begin
         if (fl_all_i) begin
            s_d.ent[i].valid = 1'b0;
         end else if (fl_tag_only_i && s_q.ent[i].tag == fl_tag_i) begin
            s_d.ent[i].valid = 1'b0;
         end else if (fl_idx_i && s_q.ent[i].tag == fl_tag_i &&
                      s_q.ent[i].idx == fl_idx_val_i) begin
            s_d.ent[i].valid = 1'b0;
         end
      end
      if (fill_i) begin
         s_d.ent[s_q.ptr] = fill_entry_i;
         s_d.ptr = s_q.ptr + 1'b1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : psc_array

// ### verif/xlat_checker.sv
// Port-level timing checks for the translation cache block
`timescale 1ns/100ps
module xlat_checker (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Watched ports
   input wire xlat_pkg::paging_mode_type mode_i,
   input wire logic has_dir_cache_i,
   input wire xlat_pkg::lookup_req_type lookup_i,
   input wire xlat_pkg::lookup_rsp_type lookup_o,
   input wire logic lookup_ready_o,
   input wire xlat_pkg::inv_req_type inv_i,
   input wire logic inv_done_o
);
   import xlat_pkg::*;
   logic take_q;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         take_q <= 1'b0;
      end else begin
         take_q <= lookup_i.valid && lookup_ready_o && !inv_i.valid;
      end
   end
   sequence s_take;
      lookup_i.valid && lookup_ready_o && !inv_i.valid;
   endsequence
   sequence s_inv;
      inv_i.valid;
   endsequence
   a_inv_done: assert property (s_inv |=> inv_done_o)
      else $error("done missing after invalidate");
   a_done_cause: assert property (inv_done_o |-> $past(inv_i.valid))
      else $error("done without invalidate");
   a_ready_drop: assert property (s_inv |=> !lookup_ready_o)
      else $error("ready high after invalidate");
   a_ready_back: assert property (
      s_inv ##1 !inv_i.valid |=> lookup_ready_o)
      else $error("ready not restored");
   a_lookup_answer: assert property (s_take |=> lookup_o.valid)
      else $error("taken lookup not answered");
   a_answer_cause: assert property (lookup_o.valid |-> take_q)
      else $error("answer without taken lookup");
   a_long_only: assert property (lookup_o.valid &&
      lookup_o.level inside {HIT_THIRD, HIT_TOP} |->
      $past(mode_i) == MODE_LONG)
      else $error("upper cache hit outside long mode");
   a_dir_skip: assert property (lookup_o.valid &&
      lookup_o.level == HIT_DIR |-> $past(has_dir_cache_i))
      else $error("absent directory cache answered");
endmodule : xlat_checker
bind translation_cache_lookup_invalidate xlat_checker chk (.clock_i(clock_i),
   .rst_i(rst_i), .mode_i(mode_i), .has_dir_cache_i(has_dir_cache_i),
   .lookup_i(lookup_i), .lookup_o(lookup_o), .lookup_ready_o(lookup_ready_o),
   .inv_i(inv_i), .inv_done_o(inv_done_o));

// ### verif/walk_model.sv
// Walk engine model that returns one fill per request
`timescale 1ns/100ps
module walk_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Walk command
   input wire logic req_i,
   input wire xlat_pkg::hit_level_type level_i,
   input wire logic [xlat_pkg::LIN_W-1:0] lin_i,
   input wire logic global_i,
   // Fill toward the caches
   output xlat_pkg::fill_req_type fill_o
);
   import xlat_pkg::*;
   fill_req_type fill_q;
   fill_req_type fill_d;
   always_comb begin
      fill_d = '0;
      if (req_i) begin
         fill_d.valid = 1'b1;
         fill_d.level = level_i;
         fill_d.lin = lin_i;
         fill_d.pa = {lin_i[LIN_W-1:PAGE_LSB], 4'h0};
         fill_d.attr = 8'h5a;
         fill_d.pte_low = {global_i, 8'h00};
      end
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         fill_q <= '0;
      end else begin
         fill_q <= fill_d;
      end
   end
   assign fill_o = fill_q;
endmodule : walk_model

// ### verif/translation_cache_lookup_invalidate_bench.sv
// Directed bench for translation lookup and invalidation
`timescale 1ns/100ps
module translation_cache_lookup_invalidate_bench;
   import xlat_pkg::*;
   logic clock_i, rst_i, tag_enable_i, global_page_enable_i;
   paging_mode_type mode_i;
   logic [TAG_W-1:0] address_space_tag_i;
   logic has_dir_cache_i, has_third_cache_i, has_top_cache_i;
   lookup_req_type lookup_i;
   lookup_rsp_type lookup_o;
   logic lookup_ready_o, inv_done_o, walk_req, walk_glob;
   fill_req_type fill_i;
   inv_req_type inv_i;
   hit_level_type walk_lvl;
   logic [LIN_W-1:0] walk_lin;
   int bad_count = 0;
   int tests_run = 0;
   localparam logic [LIN_W-1:0] A = 48'h0000_4020_1000;
   localparam logic [LIN_W-1:0] G = 48'h0000_7000_3000;
   localparam logic [LIN_W-1:0] B = 48'h0012_3460_0000;
   localparam logic [LIN_W-1:0] D = 48'h0000_0040_0000;
   logic [LIN_W-1:0] offs [4] = '{48'h0000_0000_0000, 48'h0000_0020_0000,
      48'h0000_4000_0000, 48'h0080_0000_0000};
   hit_level_type lv [4] = '{HIT_DIR, HIT_THIRD, HIT_TOP, HIT_NONE};
   inv_kind_type zk [2] = '{INV_BASE, INV_TASK};
   logic [3:0] ff [2] = '{4'b1011, 4'b1110};

   translation_cache_lookup_invalidate DUT (.clock_i, .rst_i, .mode_i,
      .tag_enable_i, .global_page_enable_i, .address_space_tag_i,
      .has_dir_cache_i, .has_third_cache_i, .has_top_cache_i, .lookup_i,
      .lookup_o, .lookup_ready_o, .fill_i, .inv_i, .inv_done_o);
   walk_model WALK (.clock_i, .rst_i, .req_i(walk_req), .level_i(walk_lvl),
      .lin_i(walk_lin), .global_i(walk_glob), .fill_o(fill_i));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic lookup(input logic [LIN_W-1:0] lin,
      input hit_level_type lvl);
      @(posedge clock_i);
      lookup_i <= {1'b1, lin};
      @(posedge clock_i);
      lookup_i <= '0;
      #1;
      check(lookup_o.valid, 1'b1);
      check(lookup_o.level, lvl);
      if (lvl != HIT_NONE) begin
         check(lookup_o.attr, 8'h5a);
      end
      if (lvl == HIT_TLB) begin
         check(lookup_o.pa, {lin[LIN_W-1:PAGE_LSB], 4'h0});
      end
   endtask : lookup

   task automatic fill(input hit_level_type lvl, input logic [LIN_W-1:0] lin,
      input logic g);
      @(posedge clock_i);
      walk_req <= 1'b1;
      walk_lvl <= lvl;
      walk_lin <= lin;
      walk_glob <= g;
      @(posedge clock_i);
      walk_req <= 1'b0;
      @(posedge clock_i);
      #1;
   endtask : fill

   task automatic inv(input inv_kind_type k, input logic [63:0] op,
      input logic [3:0] fl);
      @(posedge clock_i);
      inv_i <= {1'b1, k, op, fl};
      @(posedge clock_i);
      inv_i <= '0;
      #1;
      check(inv_done_o, 1'b1);
      check(lookup_ready_o, 1'b0);
      @(posedge clock_i);
      #1;
      check(lookup_ready_o, 1'b1);
   endtask : inv

   task automatic set_tag(input logic [TAG_W-1:0] t, input logic en);
      @(posedge clock_i);
      address_space_tag_i <= t;
      tag_enable_i <= en;
   endtask : set_tag

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   initial begin
      rst_i = 1'b1;
      mode_i = MODE_LONG;
      tag_enable_i = 1'b1;
      global_page_enable_i = 1'b1;
      address_space_tag_i = 12'h001;
      {has_dir_cache_i, has_third_cache_i, has_top_cache_i} = 3'b111;
      lookup_i = '0;
      inv_i = '0;
      {walk_req, walk_glob} = 2'b00;
      walk_lin = '0;
      walk_lvl = HIT_TLB;
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      check(lookup_ready_o, 1'b1);
      lookup(A, HIT_NONE);
      fill(HIT_TLB, A, 1'b0);
      lookup(A, HIT_TLB);
      set_tag(12'h002, 1'b1);
      lookup(A, HIT_NONE);
      fill(HIT_TLB, G, 1'b1);
      set_tag(12'h003, 1'b1);
      lookup(G, HIT_TLB);
      @(posedge clock_i);
      global_page_enable_i <= 1'b0;
      fill(HIT_TLB, B, 1'b1);
      global_page_enable_i <= 1'b1;
      set_tag(12'h001, 1'b1);
      for (int i = 0; i < 3; i++) begin
         fill(lv[i], B, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         lookup(B ^ offs[i], lv[i]);
      end
      @(posedge clock_i);
      has_dir_cache_i <= 1'b0;
      lookup(B, HIT_THIRD);
      @(posedge clock_i);
      has_third_cache_i <= 1'b0;
      lookup(B, HIT_TOP);
      @(posedge clock_i);
      mode_i <= MODE_EXT;
      lookup(B, HIT_NONE);
      @(posedge clock_i);
      mode_i <= MODE_LONG;
      has_top_cache_i <= 1'b0;
      lookup(B, HIT_NONE);
      for (int i = 0; i < 2; i++) begin
         @(posedge clock_i);
         mode_i <= (i == 0) ? MODE_EXT : MODE_32;
         has_dir_cache_i <= 1'b1;
         fill(HIT_DIR, D, 1'b0);
         lookup(D ^ 48'h0080_0000_0000, HIT_DIR);
         lookup(D ^ 48'h0000_0020_0000, (i == 0) ? HIT_NONE : HIT_DIR);
      end
      @(posedge clock_i);
      mode_i <= MODE_LONG;
      {has_dir_cache_i, has_third_cache_i, has_top_cache_i} <= 3'b111;
      inv(INV_PAGE, {16'h0000, A}, 4'hf);
      lookup(A, HIT_NONE);
      lookup(B, HIT_NONE);
      inv(INV_PAGE, {16'h0000, G}, 4'hf);
      lookup(G, HIT_NONE);
      set_tag(12'h000, 1'b0);
      for (int i = 0; i < 2; i++) begin
         fill(HIT_TLB, A, 1'b0);
         fill(HIT_DIR, B, 1'b0);
         inv(zk[i], 64'h0000_0000_0000_0000, 4'hc);
         lookup(A, HIT_NONE);
         lookup(B, HIT_NONE);
      end
      set_tag(12'h005, 1'b1);
      fill(HIT_TLB, A, 1'b0);
      inv(INV_BASE, 64'h8000_0000_0000_0005, 4'hf);
      lookup(A, HIT_TLB);
      inv(INV_BASE, 64'h0000_0000_0000_0005, 4'hf);
      lookup(A, HIT_NONE);
      fill(HIT_TLB, G, 1'b1);
      inv(INV_FEATURE, 64'h0000_0000_0000_0000, 4'hf);
      lookup(G, HIT_TLB);
      for (int i = 0; i < 2; i++) begin
         fill(HIT_TLB, G, 1'b1);
         fill(HIT_DIR, B, 1'b0);
         inv(INV_FEATURE, 64'h0000_0000_0000_0000, ff[i]);
         lookup(G, HIT_NONE);
         lookup(B, HIT_NONE);
      end
      fill(HIT_TLB, A, 1'b0);
      fill(HIT_DIR, A, 1'b0);
      lookup(A, HIT_TLB);
      inv(INV_FAULT, {16'h0000, A}, 4'hf);
      lookup(A, HIT_NONE);
      fill(HIT_TLB, A, 1'b0);
      @(posedge clock_i);
      inv_i <= {1'b1, INV_FAULT, 16'h0000, A, 4'hf};
      lookup_i <= {1'b1, A};
      @(posedge clock_i);
      inv_i <= '0;
      lookup_i <= '0;
      #1;
      check(lookup_o.valid, 1'b0);
      lookup(A, HIT_NONE);
      print_verdict();
   end
endmodule : translation_cache_lookup_invalidate_bench
